// *** logic/spk_consts.svh ***
`ifndef SPK_CONSTS_SVH
`define SPK_CONSTS_SVH
`define IDX_ATTEN 10'h023
`define IDX_BOOST 10'h025
`define IDX_MIXER 10'h036
`define IDX_ANTIPOP 10'h038
`define IDX_POWER 10'h040
`define IDX_STATUS 10'h041
`define BIT_LINEAR_MODE 8
`define BIT_REF_SEL 8
`define BIT_MIDRAIL_BUF 7
`define MSB_LEFT_GAIN 5
`define LSB_LEFT_GAIN 3
`define MSB_RIGHT_GAIN 2
`define LSB_RIGHT_GAIN 0
`define BIT_PWR_LEFT 0
`define BIT_PWR_RIGHT 1
`define BIT_PWR_EAR_IN 2
`define BIT_PWR_EAR_OUT 3
`define BIT_PWR_LINE_ONE 4
`define BIT_PWR_LINE_TWO 5
`define BIT_ST_RUNNING 0
`define BIT_ST_MIDRAIL 1
`define BIT_ST_BRIDGE 2
`define BIT_ST_EAR_EARLY 3
`define BIT_ST_GAIN_LIVE 4
`define BIT_ST_BRIDGE_PIN 5
`define RST_BIT 1'b0
`define RST_GAIN 3'h0
`define CLK_PERIOD_NS 25
`define EAR_SETTLE_NS 50000
`define EAR_SETTLE_CYC ((`EAR_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** logic/spk_pkg.sv ***
package spk_pkg;
   typedef enum logic [1:0] {
      SW_IDLE = 2'b01,
      SW_RUN  = 2'b10
   } sw_state_e;
   typedef logic [6:0]  half_period_t;
   typedef logic [3:0]  rate_code_t;
   typedef logic [9:0]  word_idx_t;
   typedef logic [15:0] reg_word_t;
endpackage : spk_pkg

// *** logic/axil_reg_port.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spk_consts.svh"
module axil_reg_port
   import spk_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   output logic             wr_pulse,
   output word_idx_t        wr_idx,
   output reg_word_t        wr_data,
   output logic [1:0]       wr_strb,
   input  wire logic        wr_ok,
   output word_idx_t        rd_idx,
   input  wire reg_word_t   rd_data,
   input  wire logic        rd_ok
);
   logic aw_held;
   logic w_held;

   assign awready  = ce && !aw_held && !bvalid;
   assign wready   = ce && !w_held && !bvalid;
   assign arready  = ce && !rvalid;
   assign wr_pulse = ce && aw_held && w_held && !bvalid;
   assign rd_idx   = araddr[11:2];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         wr_idx  <= '0;
         wr_data <= '0;
         wr_strb <= '0;
         bvalid  <= 1'b0;
         bresp   <= `RESP_OKAY;
      end else if (ce) begin
         if (awvalid && awready) begin
            aw_held <= 1'b1;
            wr_idx  <= awaddr[11:2];
         end
         if (wvalid && wready) begin
            w_held  <= 1'b1;
            wr_data <= wdata[15:0];
            wr_strb <= wstrb[1:0];
         end
         if (wr_pulse) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid  <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= `RESP_OKAY;
      end else if (ce) begin
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= {16'h0000, rd_ok ? rd_data : 16'h0000};
            rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule : axil_reg_port
`default_nettype wire

// *** logic/classd_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module classd_clk_div
   import spk_pkg::*;
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         ce,
   input  wire logic         run,
   input  wire logic         tick,
   input  wire half_period_t half_period,
   output logic              sw_clk,
   output logic              running
);
   sw_state_e    state;
   half_period_t acc;
   half_period_t p_lat;

   // accumulator counts half system-clock periods, two per tick
   wire [7:0] acc_step = {1'b0, acc} + 8'h02;
   wire       boundary = tick && (acc_step >= {1'b0, p_lat});
   wire       go       = run && (half_period != '0);
   wire       start    = (state == SW_IDLE) && go;
   wire       stop     = (state == SW_RUN) && boundary && !go;
   wire       reload   = start || ((state == SW_RUN) && boundary && go);

   wire sw_state_e    next_state = start ? SW_RUN : (stop ? SW_IDLE : state);
   wire half_period_t next_p     = reload ? half_period : p_lat;
   wire half_period_t next_acc   =
      (start || stop) ? '0 :
      boundary ? half_period_t'(acc_step - {1'b0, p_lat}) :
      (tick && state == SW_RUN) ? half_period_t'(acc_step) : acc;

   assign running = (state == SW_RUN);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state  <= SW_IDLE;
         acc    <= '0;
         p_lat  <= '0;
         sw_clk <= 1'b0;
      end else if (ce) begin
         state  <= next_state;
         acc    <= next_acc;
         p_lat  <= next_p;
         sw_clk <= (next_state == SW_RUN) && (next_acc < (next_p >> 1));
      end
   end

   AST_DIV_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && state == SW_RUN && !boundary) |=> p_lat == $past(p_lat))
      else $error("divider changed inside a period");

   AST_IDLE_LOW: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && stop) |=> !sw_clk && !running)
      else $error("switching clock not stopped at boundary");
endmodule : classd_clk_div
`default_nettype wire

// *** logic/speaker_output_mode_and_switch_clock.sv ***
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "spk_consts.svh"
module speaker_output_mode_and_switch_clock
   import spk_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   input  wire logic [11:0] awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [11:0] araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        sysclk_tick,
   input  wire rate_code_t  sysclk_ratio_code,
   input  wire rate_code_t  sample_rate_code,
   input  wire logic        speaker_bridge_pin,
   output logic             classd_switch_clk,
   output logic             speaker_linear_mode_sel,
   output logic             linear_mode_ref_sel,
   output logic [2:0]       left_spk_gain_step,
   output logic [2:0]       right_spk_gain_step,
   output logic             left_spk_drv_en,
   output logic             right_spk_drv_en,
   output logic             earpiece_input_stage_en,
   output logic             earpiece_out_stage_en,
   output logic             line_midrail_buffer_en,
   output logic             line_pair_one_ended_sel,
   output logic             line_pair_two_ended_sel
);
   // twice the divide ratio; rows are sample rates, columns clock ratios
   localparam int NUM_RATES  = 9;
   localparam int NUM_RATIOS = 10;
   localparam half_period_t HP_TABLE [NUM_RATES][NUM_RATIOS] = '{
      '{7'h04, 7'h08, 7'h0C, 7'h0C, 7'h18, 7'h18, 7'h30, 7'h30, 7'h40, 7'h60},
      '{7'h04, 7'h08, 7'h0C, 7'h10, 7'h18, 7'h20, 7'h30, 7'h40, 7'h00, 7'h00},
      '{7'h04, 7'h08, 7'h0C, 7'h10, 7'h18, 7'h20, 7'h30, 7'h40, 7'h00, 7'h00},
      '{7'h08, 7'h0C, 7'h10, 7'h18, 7'h20, 7'h30, 7'h40, 7'h00, 7'h00, 7'h00},
      '{7'h08, 7'h10, 7'h18, 7'h20, 7'h30, 7'h40, 7'h00, 7'h00, 7'h00, 7'h00},
      '{7'h09, 7'h10, 7'h18, 7'h20, 7'h30, 7'h40, 7'h00, 7'h00, 7'h00, 7'h00},
      '{7'h0C, 7'h18, 7'h20, 7'h30, 7'h40, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
      '{7'h10, 7'h20, 7'h30, 7'h40, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00},
      '{7'h10, 7'h20, 7'h30, 7'h40, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00}
   };
   localparam logic [10:0] EAR_CYC = 11'(`EAR_SETTLE_CYC);

   function automatic logic reg_hit(input word_idx_t idx);
      reg_hit = (idx == `IDX_ATTEN) || (idx == `IDX_BOOST) ||
                (idx == `IDX_MIXER) || (idx == `IDX_ANTIPOP) ||
                (idx == `IDX_POWER) || (idx == `IDX_STATUS);
   endfunction : reg_hit

   function automatic half_period_t lookup_hp(input rate_code_t r,
                                              input rate_code_t q);
      lookup_hp = '0;
      if (int'(r) < NUM_RATES && int'(q) < NUM_RATIOS) begin
         lookup_hp = HP_TABLE[r][q];
      end
   endfunction : lookup_hp

   logic        wr_pulse;
   word_idx_t   wr_idx;
   reg_word_t   wr_data;
   logic [1:0]  wr_strb;
   word_idx_t   rd_idx;
   reg_word_t   rd_data;

   logic        linear_mode;
   logic        ref_sel;
   logic        buf_en;
   logic [2:0]  gain_l;
   logic [2:0]  gain_r;
   logic [5:0]  pwr;
   logic        ear_early;
   logic        gain_live;
   logic        bridge_s1;
   logic        bridge_s2;
   logic [10:0] ear_cnt;
   logic        sw_running;

   axil_reg_port u_port (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .awaddr  (awaddr),
      .awvalid (awvalid),
      .awready (awready),
      .wdata   (wdata),
      .wstrb   (wstrb),
      .wvalid  (wvalid),
      .wready  (wready),
      .bresp   (bresp),
      .bvalid  (bvalid),
      .bready  (bready),
      .araddr  (araddr),
      .arvalid (arvalid),
      .arready (arready),
      .rdata   (rdata),
      .rresp   (rresp),
      .rvalid  (rvalid),
      .rready  (rready),
      .wr_pulse(wr_pulse),
      .wr_idx  (wr_idx),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_ok   (reg_hit(wr_idx)),
      .rd_idx  (rd_idx),
      .rd_data (rd_data),
      .rd_ok   (reg_hit(rd_idx))
   );

   // write decode
   wire wr_atten   = wr_pulse && (wr_idx == `IDX_ATTEN);
   wire wr_boost   = wr_pulse && (wr_idx == `IDX_BOOST);
   wire wr_mixer   = wr_pulse && (wr_idx == `IDX_MIXER);
   wire wr_antipop = wr_pulse && (wr_idx == `IDX_ANTIPOP);
   wire wr_power   = wr_pulse && (wr_idx == `IDX_POWER);
   wire wr_status  = wr_pulse && (wr_idx == `IDX_STATUS);

   wire next_linear = (wr_atten && wr_strb[1]) ?
                      wr_data[`BIT_LINEAR_MODE] : linear_mode;
   wire next_ref    = (wr_mixer && wr_strb[1]) ?
                      wr_data[`BIT_REF_SEL] : ref_sel;
   wire next_buf    = (wr_antipop && wr_strb[0]) ?
                      wr_data[`BIT_MIDRAIL_BUF] : buf_en;
   wire [2:0] next_gain_l = (wr_boost && wr_strb[0]) ?
                      wr_data[`MSB_LEFT_GAIN:`LSB_LEFT_GAIN] : gain_l;
   wire [2:0] next_gain_r = (wr_boost && wr_strb[0]) ?
                      wr_data[`MSB_RIGHT_GAIN:`LSB_RIGHT_GAIN] : gain_r;
   wire [5:0] next_pwr = (wr_power && wr_strb[0]) ? wr_data[5:0] : pwr;

   wire spk_on = pwr[`BIT_PWR_LEFT] || pwr[`BIT_PWR_RIGHT];
   wire sw_run = spk_on && !linear_mode;
   wire line_single = pwr[`BIT_PWR_LINE_ONE] || pwr[`BIT_PWR_LINE_TWO];
   wire midrail_missing = line_single && !buf_en;
   wire bridge_bad = bridge_s2 &&
                     !(pwr[`BIT_PWR_LEFT] && pwr[`BIT_PWR_RIGHT]);
   wire ear_rise = next_pwr[`BIT_PWR_EAR_OUT] && !pwr[`BIT_PWR_EAR_OUT];
   wire ear_early_evt = ear_rise && (ear_cnt < EAR_CYC);
   wire gain_change = (next_gain_l != gain_l) || (next_gain_r != gain_r);
   wire gain_live_evt = wr_boost && spk_on && gain_change;
   wire clr_early = wr_status && wr_strb[0] && wr_data[`BIT_ST_EAR_EARLY];
   wire clr_live = wr_status && wr_strb[0] && wr_data[`BIT_ST_GAIN_LIVE];
   wire half_period_t hp = lookup_hp(sample_rate_code, sysclk_ratio_code);

   wire reg_word_t status_word = reg_word_t'({
      bridge_s2, gain_live, ear_early, bridge_bad,
      midrail_missing, sw_running});
   wire reg_word_t rd_word_a =
      (rd_idx == `IDX_ATTEN) ? reg_word_t'({linear_mode, 8'h00}) :
      (rd_idx == `IDX_BOOST) ? reg_word_t'({gain_l, gain_r}) :
      (rd_idx == `IDX_MIXER) ? reg_word_t'({ref_sel, 8'h00}) : '0;
   wire reg_word_t rd_word_b =
      (rd_idx == `IDX_ANTIPOP) ? reg_word_t'({buf_en, 7'h00}) :
      (rd_idx == `IDX_POWER) ? reg_word_t'(pwr) :
      (rd_idx == `IDX_STATUS) ? status_word : '0;
   assign rd_data = rd_word_a | rd_word_b;

   // control fields
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         linear_mode <= `RST_BIT;
         ref_sel     <= `RST_BIT;
         buf_en      <= `RST_BIT;
         gain_l      <= `RST_GAIN;
         gain_r      <= `RST_GAIN;
         pwr         <= '0;
      end else if (ce) begin
         linear_mode <= next_linear;
         gain_l      <= next_gain_l;
         gain_r      <= next_gain_r;
         ref_sel     <= next_ref;
         buf_en      <= next_buf;
         pwr         <= next_pwr;
      end
   end

   // sticky flags, set wins over clear
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ear_early <= 1'b0;
         gain_live <= 1'b0;
      end else if (ce) begin
         ear_early <= ear_early_evt || (ear_early && !clr_early);
         gain_live <= gain_live_evt || (gain_live && !clr_live);
      end
   end

   // settle time since earpiece input stage came on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ear_cnt <= '0;
      end else if (ce) begin
         if (!pwr[`BIT_PWR_EAR_IN]) begin
            ear_cnt <= '0;
         end else if (ear_cnt < EAR_CYC) begin
            ear_cnt <= ear_cnt + 11'h001;
         end
      end
   end

   // bridge pin synchroniser and driven right gain step output
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bridge_s1           <= 1'b0;
         bridge_s2           <= 1'b0;
         right_spk_gain_step <= `RST_GAIN;
      end else if (ce) begin
         bridge_s1           <= speaker_bridge_pin;
         bridge_s2           <= bridge_s1;
         right_spk_gain_step <= bridge_s2 ? gain_l : gain_r;
      end
   end

   classd_clk_div u_div (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .ce         (ce),
      .run        (sw_run),
      .tick       (sysclk_tick),
      .half_period(hp),
      .sw_clk     (classd_switch_clk),
      .running    (sw_running)
   );

   assign speaker_linear_mode_sel = linear_mode;
   assign linear_mode_ref_sel     = ref_sel;
   assign left_spk_gain_step      = gain_l;
   assign left_spk_drv_en         = pwr[`BIT_PWR_LEFT];
   assign right_spk_drv_en        = pwr[`BIT_PWR_RIGHT];
   assign earpiece_input_stage_en = pwr[`BIT_PWR_EAR_IN];
   assign earpiece_out_stage_en   = pwr[`BIT_PWR_EAR_OUT];
   assign line_midrail_buffer_en  = buf_en;
   assign line_pair_one_ended_sel = pwr[`BIT_PWR_LINE_ONE];
   assign line_pair_two_ended_sel = pwr[`BIT_PWR_LINE_TWO];

   AST_LINEAR_RESET: assert property (@(posedge aclk)
      !$past(aresetn) |-> !speaker_linear_mode_sel && !linear_mode_ref_sel)
      else $error("mode bits not cleared by reset");

   AST_LEFT_GAIN: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && wr_boost && wr_strb[0]) |=>
         left_spk_gain_step == $past(wr_data[5:3]))
      else $error("left gain step not stored");

   AST_RIGHT_GAIN: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && wr_boost && wr_strb[0]) ##1 (ce && !bridge_s2) |=>
         right_spk_gain_step == $past(wr_data[2:0], 2))
      else $error("right gain step not driven");

   AST_REF_SEL: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && wr_mixer && wr_strb[1]) |=>
         linear_mode_ref_sel == $past(wr_data[8]))
      else $error("reference select not stored");

   AST_LINEAR_STOPS: assert property (@(posedge aclk) disable iff (!aresetn)
      (!sw_running && !sw_run) |=> !sw_running || $past(sw_run))
      else $error("switching clock started without enable");

   AST_RATE_352K8: assert property (@(posedge aclk) disable iff (!aresetn)
      (sample_rate_code == 4'h7 && sysclk_ratio_code < 4'h4) |->
         hp == half_period_t'({sysclk_ratio_code + 4'h1, 4'h0}))
      else $error("wrong divider at 44.1 kHz");

   AST_RATE_384K: assert property (@(posedge aclk) disable iff (!aresetn)
      (sample_rate_code == 4'h8 && sysclk_ratio_code < 4'h4) |->
         hp == half_period_t'({sysclk_ratio_code + 4'h1, 4'h0}))
      else $error("wrong divider at 48 kHz");

   AST_RATE_8K: assert property (@(posedge aclk) disable iff (!aresetn)
      (sample_rate_code == 4'h0 && sysclk_ratio_code == 4'h8) |->
         hp == 7'h40)
      else $error("wrong divider at 8 kHz ratio 1408");

   AST_EAR_ENABLES: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && wr_power && wr_strb[0]) |=>
         earpiece_input_stage_en == $past(wr_data[2]) &&
         earpiece_out_stage_en == $past(wr_data[3]))
      else $error("earpiece enables not independent");

   AST_MIDRAIL_BUF: assert property (@(posedge aclk) disable iff (!aresetn)
      (ce && wr_antipop && wr_strb[0]) |=>
         line_midrail_buffer_en == $past(wr_data[7]))
      else $error("midrail buffer enable not stored");

   AST_MIDRAIL_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_idx == `IDX_STATUS) |->
         rd_data[1] == ((line_pair_one_ended_sel || line_pair_two_ended_sel)
                        && !line_midrail_buffer_en))
      else $error("midrail status wrong");
endmodule : speaker_output_mode_and_switch_clock
`default_nettype wire

// *** dv/axil_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module axil_host
   import spk_pkg::*;
(
   input  wire logic        aclk,
   output logic [11:0]      awaddr,
   output logic             awvalid,
   input  wire logic        awready,
   output logic [31:0]      wdata,
   output logic [3:0]       wstrb,
   output logic             wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output logic             bready,
   output logic [11:0]      araddr,
   output logic             arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output logic             rready
);
   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   // handshakes sampled at the rising edge that takes them, released there
   task automatic wr(input word_idx_t i, input reg_word_t v,
                     output logic [1:0] r);
      logic a, w, b;
      @(posedge aclk);
      awaddr  <= {i, 2'b00};
      awvalid <= 1'b1;
      wdata   <= {16'h0000, v};
      wstrb   <= 4'hF;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(posedge aclk);
         a = awvalid & awready;
         w = wvalid & wready;
         b = bvalid & bready;
         r = bresp;
         if (a) awvalid <= 1'b0;
         if (w) wvalid <= 1'b0;
         if (b) bready <= 1'b0;
      end
   endtask : wr
   task automatic rd(input word_idx_t i, output reg_word_t v,
                     output logic [1:0] r);
      logic a, b;
      @(posedge aclk);
      araddr  <= {i, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      b = 1'b0;
      while (!b) begin
         @(posedge aclk);
         a = arvalid & arready;
         b = rvalid & rready;
         v = rdata[15:0];
         r = rresp;
         if (a) arvalid <= 1'b0;
         if (b) rready <= 1'b0;
      end
   endtask : rd
endmodule : axil_host
`default_nettype wire

// *** dv/test_speaker_output_mode_and_switch_clock.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spk_consts.svh"
`define CHK(n, e, g) \
   begin \
      num_checks++; \
      if ((g) !== (e)) begin \
         fails++; \
         $display("unexpected %s exp %h got %h", n, e, g); \
      end \
   end
module test_speaker_output_mode_and_switch_clock
   import spk_pkg::*;
;
   logic        aclk, aresetn, ce, tick, bridge, swclk, lin, refs;
   rate_code_t  ratio, rate;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [2:0]  lg, rg;
   logic        ldrv, rdrv, ear_in, ear_out, mbuf, one_se, two_se;
   reg_word_t   d, v;
   int          fails = 0, num_checks = 0, n, k, hi;
   rate_code_t  rc [7] = '{7, 8, 0, 0, 0, 2, 1};
   rate_code_t  qc [7] = '{3, 0, 8, 0, 3, 7, 7};
   int          fs [7] = '{44100, 48000, 8000, 8000, 8000, 12000, 11025};
   int          sw [7] = '{352800, 384000, 352000, 256000, 341333, 384000,
                           352800};
   axil_host i_host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));
   speaker_output_mode_and_switch_clock i_dut (.aclk(aclk),
      .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .sysclk_tick(tick),
      .sysclk_ratio_code(ratio), .sample_rate_code(rate),
      .speaker_bridge_pin(bridge), .classd_switch_clk(swclk),
      .speaker_linear_mode_sel(lin), .linear_mode_ref_sel(refs),
      .left_spk_gain_step(lg), .right_spk_gain_step(rg),
      .left_spk_drv_en(ldrv), .right_spk_drv_en(rdrv),
      .earpiece_input_stage_en(ear_in), .earpiece_out_stage_en(ear_out),
      .line_midrail_buffer_en(mbuf), .line_pair_one_ended_sel(one_se),
      .line_pair_two_ended_sel(two_se));
   initial aclk = 1'b0;
   always #12.5 aclk = ~aclk;
   // switching period in system clock ticks, rounded
   function automatic int ticks(input int f, input rate_code_t c,
                                input int s);
      int t [10] = '{64, 128, 192, 256, 384, 512, 768, 1024, 1408, 1536};
      return (f * t[c] + s / 2) / s;
   endfunction : ticks
   task automatic rdchk(input word_idx_t i, input reg_word_t e);
      i_host.rd(i, d, r);
      `CHK("readback", e, d)
      `CHK("rresp", `RESP_OKAY, r)
   endtask : rdchk
   // skips the first period, which may straddle a divider change
   task automatic meas(output int p);
      int t1, ks;
      logic last;
      p = 0;
      ks = 0;
      t1 = 0;
      last = 1'b1;
      for (int t = 0; t < 400 && p == 0; t++) begin
         @(negedge aclk);
         if (swclk === 1'b1 && last === 1'b0) begin
            ks++;
            if (ks == 2) t1 = t;
            if (ks == 3) p = t - t1;
         end
         last = swclk;
      end
   endtask : meas
   task automatic still(input string s);
      repeat (80) @(posedge aclk);
      hi = 0;
      repeat (64) begin
         @(negedge aclk);
         if (swclk !== 1'b0) hi = 1;
      end
      `CHK(s, 0, hi)
   endtask : still
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude
   initial begin
      repeat (40000) @(posedge aclk);
      fails++;
      conclude();
   end
   initial begin
      {aresetn, bridge, ratio, rate} = '0;
      ce = 1'b1;
      tick = 1'b1;
      void'($urandom(86551));
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK("out_reset", 0, {lin, refs, lg, rg, mbuf, swclk})
      rdchk(`IDX_ATTEN, 16'h0000);
      rdchk(`IDX_BOOST, 16'h0000);
      rdchk(`IDX_MIXER, 16'h0000);
      rdchk(`IDX_ANTIPOP, 16'h0000);
      $display("test reset done");
      i_host.wr(`IDX_ATTEN, 16'h0100, r);
      i_host.wr(`IDX_MIXER, 16'h0100, r);
      i_host.wr(`IDX_ANTIPOP, 16'h0080, r);
      `CHK("mode_bits", 3'h7, {lin, refs, mbuf})
      rdchk(`IDX_ANTIPOP, 16'h0080);
      i_host.wr(`IDX_ATTEN, 16'h0000, r);
      `CHK("mode_clear", 1'h0, lin)
      for (k = 0; k < 10; k++) begin
         v = (k == 0) ? 16'h003F : 16'($urandom) & 16'h003F;
         i_host.wr(`IDX_BOOST, v, r);
         `CHK("bresp_ok", `RESP_OKAY, r)
         @(negedge aclk);
         `CHK("left_gain", v[5:3], lg)
         `CHK("right_gain", v[2:0], rg)
         rdchk(`IDX_BOOST, v);
      end
      i_host.wr(10'h3FF, 16'hFFFF, r);
      `CHK("bresp_unmapped", `RESP_SLVERR, r)
      i_host.rd(10'h3FF, d, r);
      `CHK("rresp_unmapped", `RESP_SLVERR, r)
      `CHK("rdata_unmapped", 16'h0000, d)
      $display("test fields done");
      i_host.wr(`IDX_POWER, 16'h0004, r);
      `CHK("ear_input_only", 2'h2, {ear_in, ear_out})
      repeat (`EAR_SETTLE_CYC + 50) @(posedge aclk);
      i_host.wr(`IDX_POWER, 16'h003C, r);
      `CHK("ear_line", 4'hF, {ear_in, ear_out, one_se, two_se})
      rdchk(`IDX_STATUS, 16'h0000);
      i_host.wr(`IDX_POWER, 16'h0000, r);
      i_host.wr(`IDX_ANTIPOP, 16'h0000, r);
      i_host.wr(`IDX_POWER, 16'h003C, r);
      rdchk(`IDX_STATUS, 16'h000A);
      i_host.wr(`IDX_STATUS, 16'h0008, r);
      i_host.wr(`IDX_ANTIPOP, 16'h0080, r);
      rdchk(`IDX_STATUS, 16'h0000);
      $display("test power done");
      i_host.wr(`IDX_POWER, 16'h0001, r);
      for (k = 0; k < 7; k++) begin
         @(posedge aclk);
         rate <= rc[k];
         ratio <= qc[k];
         repeat (100) @(posedge aclk);
         meas(n);
         `CHK("sw_period", ticks(fs[k], qc[k], sw[k]), n)
      end
      i_host.wr(`IDX_ATTEN, 16'h0100, r);
      still("stop_linear");
      i_host.wr(`IDX_ATTEN, 16'h0000, r);
      i_host.wr(`IDX_POWER, 16'h0002, r);
      meas(n);
      `CHK("sw_right_only", 32, n)
      i_host.wr(`IDX_POWER, 16'h0000, r);
      still("stop_disabled");
      i_host.wr(`IDX_POWER, 16'h0001, r);
      rate <= 4'h7;
      ratio <= 4'h5;
      still("stop_blank");
      $display("test switch clock done");
      i_host.wr(`IDX_POWER, 16'h0000, r);
      i_host.wr(`IDX_BOOST, 16'h0028, r);
      bridge <= 1'b1;
      i_host.wr(`IDX_POWER, 16'h0003, r);
      repeat (5) @(posedge aclk);
      `CHK("bridge_right", 3'h5, rg)
      `CHK("drv_en", 2'h3, {ldrv, rdrv})
      rdchk(`IDX_STATUS, 16'h0020);
      bridge <= 1'b0;
      repeat (5) @(posedge aclk);
      `CHK("stereo_right", 3'h0, rg)
      i_host.wr(`IDX_BOOST, 16'h0029, r);
      rdchk(`IDX_STATUS, 16'h0010);
      $display("test bridge done");
      conclude();
   end
endmodule : test_speaker_output_mode_and_switch_clock
`default_nettype wire
